// [alu_pkg.sv]
/*
 * Shared types and constants of the eight-bit arithmetic and logic unit.
 * Assumes it is compiled before every other file of the block.
 */
package alu_pkg;

    // ------------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam int MSB = 7;
    localparam int HALF_MSB = 3;

    // ------------------------------------------------------------------
    // Operation codes and sequencer phases
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ALU_SUM_REGS,
        ALU_SUM_REGS_WITH_CARRY,
        ALU_SUM_IMM_WORD,
        ALU_DIFF_REGS,
        ALU_DIFF_IMM,
        ALU_DIFF_REGS_BORROW,
        ALU_DIFF_IMM_BORROW,
        ALU_DIFF_IMM_WORD,
        ALU_BITWISE_CONJ_REGS,
        ALU_BITWISE_CONJ_IMM,
        ALU_BITWISE_DISJ_REGS,
        ALU_DISJ_IMM,
        ALU_EXCLUSIVE_DISJ_REGS,
        ALU_BIT_INVERT,
        ALU_SIGN_FLIP
    } alu_op_t;

    typedef enum logic {
        ALU_PH_FIRST,
        ALU_PH_WORD_HI
    } alu_phase_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
        logic h;
    } alu_flags_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [7:0] dest_lo;
        logic [7:0] dest_hi;
        logic [7:0] source_reg;
        logic [7:0] immediate_const;
    } alu_req_t;

    typedef struct packed {
        logic lo_en;
        logic hi_en;
        logic [7:0] lo;
        logic [7:0] hi;
    } alu_wb_t;

endpackage

// [alu_addsub8.sv]
/*
 * Eight-bit adder/subtractor with carry, half-carry and overflow outputs.
 * Assumes purely combinational use; subtraction reports borrow in cout.
 */
module alu_addsub8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [7:0] sum,
    output logic cout,
    output logic half,
    output logic ovf
);

    logic [7:0] b_eff;
    logic [8:0] full;
    logic [4:0] low;

    // ------------------------------------------------------------------
    // Sum and flag terms
    // ------------------------------------------------------------------
    // Subtraction is a + ~b + ~borrow; the carries are inverted to borrows.
    always_comb begin
        b_eff = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin ^ sub};
        low = {1'b0, a[alu_pkg::HALF_MSB:0]}
            + {1'b0, b_eff[alu_pkg::HALF_MSB:0]}
            + {4'h0, cin ^ sub};
        sum = full[7:0];
        cout = full[8] ^ sub;
        half = low[4] ^ sub;
        ovf = (a[alu_pkg::MSB] == b_eff[alu_pkg::MSB])
            & (sum[alu_pkg::MSB] != a[alu_pkg::MSB]);
    end

endmodule

// [alu_core.sv]
/*
 * Eight-bit arithmetic and logic datapath with its own status flags.
 * Assumes the decoder presents one request at a time while busy is low,
 * and the register file writes back the bytes marked by wb.
 */
// Overview of operation
// - add registers, optional carry, one clock, ZCNVH
// - word add immediate, two clocks, ZCNVS
// - word subtract immediate, write both bytes, ZCNVS
// - subtract, borrow subtract, negate: one clock ZCNVH
// - subtract immediate from destination, ZCNVH, one clock
// - subtract immediate and carry, ZCNVH
// - AND with register or immediate: ZNV
// - OR, XOR update ZNV; complement updates ZCNV
module alu_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire alu_pkg::alu_req_t req,
    output logic busy,
    output logic done,
    output alu_pkg::alu_wb_t wb,
    output alu_pkg::alu_flags_t flags
);

    typedef struct packed {
        alu_pkg::alu_phase_t phase;
        alu_pkg::alu_op_t op;
        logic [7:0] dest_hi;
        logic [7:0] res_lo;
        logic carry_lo;
        logic zero_lo;
        logic busy;
        logic done;
        alu_pkg::alu_wb_t wb;
        alu_pkg::alu_flags_t flags;
    } alu_state_t;

    alu_state_t state;
    alu_state_t next_state;

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic add_sub;
    logic [7:0] add_sum;
    logic add_cout;
    logic add_half;
    logic add_ovf;
    logic [7:0] logic_res;
    logic [7:0] byte_res;
    logic is_arith;
    logic is_logic;
    logic is_word;

    // ------------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------------
    // One adder serves both the byte add and subtract operations and each word phase.
    always_comb begin
        add_a = req.dest_lo;
        add_b = req.source_reg;
        add_cin = 1'b0;
        add_sub = 1'b0;
        if (state.phase == alu_pkg::ALU_PH_WORD_HI) begin
            // High byte takes the low byte's carry or borrow.
            add_a = state.dest_hi;
            add_b = alu_pkg::ZERO_BYTE;
            add_cin = state.carry_lo;
            add_sub = (state.op == alu_pkg::ALU_DIFF_IMM_WORD);
        end else begin
            case (req.op)
                alu_pkg::ALU_SUM_REGS_WITH_CARRY: begin
                    add_cin = state.flags.c;
                end
                alu_pkg::ALU_SUM_IMM_WORD: begin
                    add_b = req.immediate_const;
                end
                alu_pkg::ALU_DIFF_REGS: begin
                    add_sub = 1'b1;
                end
                alu_pkg::ALU_DIFF_REGS_BORROW: begin
                    add_sub = 1'b1;
                    add_cin = state.flags.c;
                end
                alu_pkg::ALU_DIFF_IMM: begin
                    add_b = req.immediate_const;
                    add_sub = 1'b1;
                end
                alu_pkg::ALU_DIFF_IMM_BORROW: begin
                    add_b = req.immediate_const;
                    add_sub = 1'b1;
                    add_cin = state.flags.c;
                end
                alu_pkg::ALU_DIFF_IMM_WORD: begin
                    add_b = req.immediate_const;
                    add_sub = 1'b1;
                end
                alu_pkg::ALU_SIGN_FLIP: begin
                    // Negation is zero minus the destination.
                    add_a = alu_pkg::ZERO_BYTE;
                    add_b = req.dest_lo;
                    add_sub = 1'b1;
                end
                default: begin
                    add_cin = 1'b0;
                end
            endcase
        end
    end

    alu_addsub8 u_addsub (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sub(add_sub),
        .sum(add_sum),
        .cout(add_cout),
        .half(add_half),
        .ovf(add_ovf)
    );

    // ------------------------------------------------------------------
    // Bitwise results
    // ------------------------------------------------------------------
    // Logic operations never touch the adder.
    always_comb begin
        is_logic = 1'b1;
        is_arith = 1'b0;
        is_word = 1'b0;
        case (req.op)
            alu_pkg::ALU_BITWISE_CONJ_REGS: begin
                logic_res = req.dest_lo & req.source_reg;
            end
            alu_pkg::ALU_BITWISE_CONJ_IMM: begin
                logic_res = req.dest_lo & req.immediate_const;
            end
            alu_pkg::ALU_BITWISE_DISJ_REGS: begin
                logic_res = req.dest_lo | req.source_reg;
            end
            alu_pkg::ALU_DISJ_IMM: begin
                logic_res = req.dest_lo | req.immediate_const;
            end
            alu_pkg::ALU_EXCLUSIVE_DISJ_REGS: begin
                logic_res = req.dest_lo ^ req.source_reg;
            end
            alu_pkg::ALU_BIT_INVERT: begin
                logic_res = alu_pkg::ALL_ONES - req.dest_lo;
            end
            alu_pkg::ALU_SUM_IMM_WORD, alu_pkg::ALU_DIFF_IMM_WORD: begin
                logic_res = alu_pkg::ZERO_BYTE;
                is_logic = 1'b0;
                is_word = 1'b1;
            end
            default: begin
                logic_res = alu_pkg::ZERO_BYTE;
                is_logic = 1'b0;
                is_arith = 1'b1;
            end
        endcase
        byte_res = is_logic ? logic_res : add_sum;
    end

    // ------------------------------------------------------------------
    // Sequencer and flag update
    // ------------------------------------------------------------------
    // Flags not named for an operation keep their value; the source
    // register is never a write-back target.
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        next_state.wb.lo_en = 1'b0;
        next_state.wb.hi_en = 1'b0;
        case (state.phase)
            alu_pkg::ALU_PH_FIRST: begin
                if (req.valid) begin
                    next_state.op = req.op;
                    if (is_word) begin
                        // Low byte now, high byte next clock.
                        next_state.phase = alu_pkg::ALU_PH_WORD_HI;
                        next_state.dest_hi = req.dest_hi;
                        next_state.res_lo = add_sum;
                        next_state.carry_lo = add_cout;
                        next_state.zero_lo = (add_sum == alu_pkg::ZERO_BYTE);
                        next_state.busy = 1'b1;
                    end else begin
                        next_state.done = 1'b1;
                        next_state.wb.lo_en = 1'b1;
                        next_state.wb.lo = byte_res;
                        next_state.flags.z = (byte_res == alu_pkg::ZERO_BYTE);
                        next_state.flags.n = byte_res[alu_pkg::MSB];
                        if (is_arith) begin
                            // Add and subtract family.
                            next_state.flags.c = add_cout;
                            next_state.flags.h = add_half;
                            next_state.flags.v = add_ovf;
                        end else begin
                            next_state.flags.v = 1'b0;
                            if (req.op == alu_pkg::ALU_BIT_INVERT) begin
                                next_state.flags.c = 1'b1;
                            end
                        end
                    end
                end
            end
            alu_pkg::ALU_PH_WORD_HI: begin
                // Flags describe the whole sixteen-bit result.
                next_state.phase = alu_pkg::ALU_PH_FIRST;
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
                next_state.wb.lo_en = 1'b1;
                next_state.wb.hi_en = 1'b1;
                next_state.wb.lo = state.res_lo;
                next_state.wb.hi = add_sum;
                next_state.flags.z = state.zero_lo
                    & (add_sum == alu_pkg::ZERO_BYTE);
                next_state.flags.n = add_sum[alu_pkg::MSB];
                next_state.flags.c = add_cout;
                next_state.flags.v = add_ovf;
                next_state.flags.s = add_sum[alu_pkg::MSB] ^ add_ovf;
            end
            default: begin
                next_state.phase = alu_pkg::ALU_PH_FIRST;
                next_state.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset; clock enable low freezes everything.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign busy = state.busy;
    assign done = state.done;
    assign wb = state.wb;
    assign flags = state.flags;

endmodule

// [alu_core_checker.sv]
/*
 * Concurrent checks on the ports of alu_core.
 * Assumes clk_en stays high across the two edges of a word op.
 */
module alu_core_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire alu_pkg::alu_req_t req,
    input wire logic busy,
    input wire logic done,
    input wire alu_pkg::alu_wb_t wb,
    input wire alu_pkg::alu_flags_t flags
);
    // -----
    // Request decode
    // -----
    // An accepted request and the kind of operation it carries.
    logic take;
    logic word;
    logic lgc;
    assign take = req.valid && !busy && clk_en;
    assign word = req.op inside {alu_pkg::ALU_SUM_IMM_WORD,
        alu_pkg::ALU_DIFF_IMM_WORD};
    assign lgc = req.op inside {alu_pkg::ALU_BITWISE_CONJ_REGS,
        alu_pkg::ALU_BITWISE_CONJ_IMM, alu_pkg::ALU_BITWISE_DISJ_REGS,
        alu_pkg::ALU_DISJ_IMM, alu_pkg::ALU_EXCLUSIVE_DISJ_REGS};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_word_take;
        take && word;
    endsequence
    sequence s_word_end;
        done && wb.lo_en && wb.hi_en && !busy;
    endsequence
    // -----
    // Properties
    // -----
    a_byte_one: assert property (take && !word |=> done && !wb.hi_en)
        else $error("byte op not done after one cycle");
    a_word_busy: assert property (s_word_take |=> busy && !done)
        else $error("word op not busy in its first cycle");
    a_word_two: assert property (s_word_take ##1 clk_en |=> s_word_end)
        else $error("word op not done after two cycles");
    a_word_flags: assert property (s_word_end |->
        flags.z == ({wb.hi, wb.lo} == 16'h0000) && flags.n == wb.hi[7]
        && flags.s == (flags.n ^ flags.v))
        else $error("word flags disagree with result");
    a_byte_zn: assert property (done && !wb.hi_en |->
        flags.z == (wb.lo == 8'h00) && flags.n == wb.lo[7])
        else $error("byte zero or negative flag wrong");
    a_logic_keep: assert property (take && lgc |=>
        !flags.v && $stable({flags.s, flags.c, flags.h}))
        else $error("logic op touched an unlisted flag");
    a_invert_res: assert property (take
        && req.op == alu_pkg::ALU_BIT_INVERT
        |=> flags.c && !flags.v && wb.lo == ~$past(req.dest_lo))
        else $error("complement result or flags wrong");
    a_sign_keep: assert property (take && !word |=> $stable(flags.s))
        else $error("byte op changed the sign flag");
endmodule
bind alu_core alu_core_checker u_chk (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .req(req), .busy(busy), .done(done), .wb(wb),
    .flags(flags));

// [tb.sv]
/*
 * Self-checking bench for alu_core.
 * Assumes the opcode order of alu_pkg and the bound checker.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    alu_pkg::alu_req_t req = '0;
    logic busy;
    logic done;
    alu_pkg::alu_wb_t wb;
    alu_pkg::alu_flags_t flags;
    alu_pkg::alu_flags_t ef = '0;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    alu_core dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
        .busy(busy), .done(done), .wb(wb), .flags(flags));
    // Clock of 10 ns period.
    always #5 clk = ~clk;
    // A hung run is cut short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Reference result; updates the expected flags as a side effect.
    function automatic logic [15:0] model(logic [3:0] o,
        logic [7:0] d, logic [7:0] dh, logic [7:0] s, logic [7:0] k);
        logic [7:0] b;
        logic [7:0] r;
        logic [15:0] w;
        logic ci;
        b = (o inside {4'h4, 4'h6, 4'h9, 4'hb}) ? k : s;
        ci = (o inside {4'h1, 4'h5, 4'h6}) & ef.c;
        if (o == 4'he) begin
            b = d;
            d = 8'h00;
        end
        if (o inside {4'h2, 4'h7}) begin
            w = (o == 4'h2) ? {dh, d} + 16'(k) : {dh, d} - 16'(k);
            ef.n = w[15];
            ef.v = (o == 4'h2) ? ~dh[7] & w[15] : dh[7] & ~w[15];
            ef.c = (o == 4'h2) ? dh[7] & ~w[15] : w[15] & ~dh[7];
            ef.z = w == 16'h0000;
            ef.s = ef.n ^ ef.v;
            return w;
        end
        if (o inside {4'h3, 4'h4, 4'h5, 4'h6, 4'he}) begin
            r = d - b - 8'(ci);
            ef.c = 9'(d) < 9'(b) + 9'(ci);
            ef.h = 5'(d[3:0]) < 5'(b[3:0]) + 5'(ci);
            ef.v = d[7] & ~b[7] & ~r[7] | ~d[7] & b[7] & r[7];
        end else if (o < 4'h8) begin
            {ef.c, r} = 9'(d) + 9'(b) + 9'(ci);
            ef.h = 5'(d[3:0]) + 5'(b[3:0]) + 5'(ci) > 5'h0f;
            ef.v = d[7] & b[7] & ~r[7] | ~d[7] & ~b[7] & r[7];
        end else begin
            r = (o < 4'ha) ? d & b : (o == 4'hc) ? d ^ b : d | b;
            ef.v = 1'b0;
            if (o == 4'hd) begin
                r = ~d;
                ef.c = 1'b1;
            end
        end
        ef.z = r == 8'h00;
        ef.n = r[7];
        return {8'h00, r};
    endfunction
    // One request; latency, result and every flag are judged.
    task automatic run(logic [3:0] o, logic [7:0] d, logic [7:0] dh,
        logic [7:0] s, logic [7:0] k);
        logic [15:0] e;
        logic w;
        w = o inside {4'h2, 4'h7};
        e = model(o, d, dh, s, k);
        @(posedge clk);
        req <= '{1'b1, alu_pkg::alu_op_t'(o), d, dh, s, k};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk("busy", busy, w);
        if (w) begin
            @(posedge clk);
            #1;
        end
        chk("done", done, 1'b1);
        chk("lo_en", wb.lo_en, 1'b1);
        chk("lo", wb.lo, e[7:0]);
        chk("hi", {wb.hi_en, wb.hi & {8{w}}}, {w, e[15:8]});
        chk("flags", flags, ef);
    endtask
    // Every opcode on operands that force carries, borrows and overflow.
    task automatic t_all_ops();
        for (int i = 0; i < 15; i++) begin
            run(4'(i), 8'h7f, 8'h7f, 8'h01, 8'h81);
            run(4'(i), 8'h08, 8'hff, 8'h09, 8'hf8);
        end
        run(4'h7, 8'h00, 8'h00, 8'h00, 8'h01);
    endtask
    // A request raised while busy leaves no trace.
    task automatic t_busy_ignore();
        logic [15:0] e;
        e = model(4'h2, 8'h10, 8'h20, 8'h00, 8'h05);
        @(posedge clk);
        req <= '{1'b1, alu_pkg::ALU_SUM_IMM_WORD, 8'h10, 8'h20, 8'h00,
            8'h05};
        @(posedge clk);
        req <= '{1'b1, alu_pkg::ALU_SUM_REGS, 8'hff, 8'h00, 8'hff, 8'h00};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk("ign_lo", wb.lo, e[7:0]);
        @(posedge clk);
        #1;
        chk("ign_done", done, 1'b0);
        chk("ign_flags", flags, ef);
    endtask
    // With the enable low a pending request waits.
    task automatic t_freeze();
        logic [15:0] e;
        @(posedge clk);
        clk_en <= 1'b0;
        req <= '{1'b1, alu_pkg::ALU_DIFF_IMM, 8'h00, 8'h00, 8'h00, 8'h01};
        repeat (3) @(posedge clk);
        #1;
        chk("frz_done", done, 1'b0);
        chk("frz_flags", flags, ef);
        e = model(4'h4, 8'h00, 8'h00, 8'h00, 8'h01);
        @(posedge clk);
        clk_en <= 1'b1;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk("sub_lo", wb.lo, e[7:0]);
        chk("sub_flags", flags, ef);
    endtask
    // A second reset clears the flags, so the carry-in is zero.
    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        ef = '0;
        chk("rst_flags", flags, ef);
        run(4'h6, 8'h05, 8'h00, 8'h00, 8'h05);
    endtask
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_all_ops();
        t_busy_ignore();
        t_freeze();
        t_reset();
        report_and_stop();
    end
endmodule
